// ---- bench/clock_power_reset_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_power_reset_control_bench;
	import cprc_pkg::*;
	logic clk = 0, rst = 1, xrst_n = 1, wr = 0, rd = 0, act = 0, pend = 0, we = 0;
	logic [7:0] a = 8'h00, d = 8'h00, rdat, ra = 8'h00, rq;
	logic [4:0] req = 5'h00, wk;
	logic cpu, per, srst, hit, busy;
	logic [3:0] w0, w1, w2, w3;
	logic [2:0] st;
	int miscompares = 0, check_count = 0;
	cprc_wake_src u_wake (.mclk_in(clk), .req_in(req), .wake_out(wk));
	cprc_top #(.DEBOUNCE_CYCLES(4)) dut (.mclk_in(clk), .rst_in(rst),
		.external_reset_low_in(xrst_n), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_addr_in(a),
		.sfr_wdata_in(d), .sfr_rdata_out(rdat), .sfr_hit_out(hit), .irq_active_in(act),
		.irq_pending_in(pend), .external_interrupt_zero_in(wk[0]),
		.external_interrupt_one_in(wk[1]), .debug_wake_in(wk[2]), .spi_rx_wake_in(wk[3]),
		.twi_wake_in(wk[4]), .cpu_clk_en_out(cpu), .periph_clk_en_out(per),
		.sys_reset_out(srst), .stretch_out(st), .rd_addr_width_out(w0),
		.rd_strobe_width_out(w1), .wr_addr_width_out(w2), .wr_strobe_width_out(w3),
		.iram_addr_in(ra), .iram_we_in(we), .iram_wdata_in(d), .iram_rdata_out(rq),
		.iram_busy_out(busy));
	initial forever #50 clk = ~clk;
	task automatic summarize();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [15:0] e, s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// Inputs move 5 ns after the edge so no race with the design's flops
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : cyc
	task automatic wt(ref logic s, input logic v, input int lim);
		int i = 0;
		while (s !== v && i < lim) begin
			cyc(1);
			i++;
		end
		chk("wait", v, s);
	endtask : wt
	task automatic sw(input logic [7:0] ad, dt);
		wr = 1;
		a = ad;
		d = dt;
		cyc(1);
		wr = 0;
		// Idle cycle keeps strobes apart and lets stale divider ticks pass
		cyc(1);
	endtask : sw
	task automatic rchk(input string n, input logic [7:0] ad, e);
		rd = 1;
		a = ad;
		#40;
		chk(n, {ad inside {8'h87, 8'h8E, 8'h94}, e}, {hit, rdat});
		cyc(1);
		rd = 0;
		cyc(1);
	endtask : rchk
	task automatic cnt(input int n, output int k);
		k = 0;
		repeat (n) begin
			k += cpu;
			cyc(1);
		end
	endtask : cnt
	task automatic t_regs();
		rchk("pm", ADDR_POWER_MODE, RST_POWER_MODE);
		rchk("str", ADDR_STRETCH, RST_STRETCH);
		rchk("cd", ADDR_CLKDIV, RST_CLKDIV);
		rchk("unmapped", 8'h88, 8'h00);
		sw(ADDR_POWER_MODE, 8'hFC);
		rchk("flags", ADDR_POWER_MODE, 8'h0C);
		chk("flag run", 2'b11, {cpu, per});
		sw(ADDR_CLKDIV, 8'h7F);
		rchk("cd rd", ADDR_CLKDIV, 8'h1F);
		for (int s = 0; s < 8; s++) begin
			sw(ADDR_STRETCH, 8'hF8 | s[7:0]);
			chk("stretch", s[2:0], st);
			chk("widths", {s[3:0] + 4'h1, s[3:0] + 4'h1, s[3:0] + 4'h2,
				s < 2 ? 4'h1 : s[3:0]}, {w0, w1, w2, w3});
		end
	endtask : t_regs
	task automatic t_div();
		int k;
		int cs[7] = '{0, 1, 3, 9, 10, 14, 15};
		foreach (cs[i]) begin
			sw(ADDR_CLKDIV, cs[i][7:0]);
			cnt((cs[i] < 10 ? 4 : 1) << cs[i], k);
			chk("div", cs[i] < 10 ? 4 : 1, k);
		end
		sw(ADDR_CLKDIV, 8'h02);
		act = 1;
		cyc(1);
		cnt(8, k);
		chk("irq full", 8, k);
		sw(ADDR_CLKDIV, 8'h12);
		cnt(8, k);
		chk("irq kept", 2, k);
		act = 0;
		sw(ADDR_CLKDIV, 8'h00);
	endtask : t_div
	task automatic t_idle();
		int k;
		sw(ADDR_POWER_MODE, 8'h0D);
		cyc(1);
		chk("idle", 2'b01, {cpu, per});
		rchk("idle rd", ADDR_POWER_MODE, 8'h0C);
		pend = 1;
		wt(cpu, 1, 4);
		pend = 0;
		cnt(4, k);
		chk("after idle", 4, k);
	endtask : t_idle
	task automatic t_stop();
		for (int j = 0; j < 5; j++) begin
			sw(ADDR_POWER_MODE, 8'h0E);
			chk("stop", 2'b00, {cpu, per});
			pend = 1;
			cyc(6);
			chk("no irq wake", 1'b0, per);
			pend = 0;
			req = 5'h01 << j;
			wt(per, 1, 8);
			req = 5'h00;
			cyc(6);
			chk("stays run", 1'b1, cpu);
			rchk("stop rd", ADDR_POWER_MODE, 8'h0C);
		end
	endtask : t_stop
	task automatic t_soft();
		we = 1;
		ra = 8'hFF;
		d = 8'hA5;
		cyc(1);
		we = 0;
		cyc(1);
		chk("ram", 8'hA5, rq);
		sw(ADDR_STRETCH, 8'h05);
		// Written inline: the pulse is gone before a full write task returns
		wr = 1;
		a = ADDR_CLKDIV;
		d = 8'h80;
		cyc(1);
		wr = 0;
		chk("soft pulse", 1'b1, srst);
		cyc(1);
		chk("one pulse", 1'b0, srst);
		wt(busy, 0, 300);
		rchk("str clr", ADDR_STRETCH, 8'h00);
		cyc(1);
		chk("ram clr", 8'h00, rq);
	endtask : t_soft
	task automatic t_pin();
		int k = 0;
		sw(ADDR_CLKDIV, 8'h03);
		xrst_n = 0;
		cyc(2);
		xrst_n = 1;
		repeat (10) begin
			k += srst;
			cyc(1);
		end
		chk("bounce", 0, k);
		xrst_n = 0;
		wt(srst, 1, 12);
		xrst_n = 1;
		wt(srst, 0, 12);
		wt(busy, 0, 300);
		rchk("pin clr", ADDR_CLKDIV, 8'h00);
	endtask : t_pin
	initial begin
		cyc(3);
		rst = 0;
		wt(busy, 0, 300);
		t_regs();
		t_div();
		t_idle();
		t_stop();
		t_soft();
		t_pin();
		summarize();
	end
	// Longest scenario is the divide-by-32768 window, about 55k cycles in all
	initial begin
		#9000000;
		miscompares++;
		summarize();
	end
endmodule : clock_power_reset_control_bench
`default_nettype wire

// ---- bench/cprc_wake_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module cprc_wake_src (
	input wire logic mclk_in, // Clock
	input wire logic [4:0] req_in, // Wake request per source
	output logic [4:0] wake_out // Held wake levels
);
	// Unclocked wake logic sees levels, so each level is held while requested
	always_ff @(posedge mclk_in) begin
		wake_out <= req_in;
	end
endmodule : cprc_wake_src
`default_nettype wire

// ---- hdl/cprc_pkg.sv ----
package cprc_pkg;
	localparam logic [7:0] ADDR_POWER_MODE = 8'h87;
	localparam logic [7:0] ADDR_STRETCH = 8'h8E;
	localparam logic [7:0] ADDR_CLKDIV = 8'h94;
	localparam int BIT_IDLE = 0;
	localparam int BIT_STOP = 1;
	localparam int BIT_FLAG0 = 2;
	localparam int BIT_FLAG1 = 3;
	localparam int BIT_SOFTWARE_RESET_TRIGGER = 7;
	localparam int BIT_IRQSPD = 4;
	localparam logic [7:0] RST_POWER_MODE = 8'h00;
	localparam logic [7:0] RST_STRETCH = 8'h00;
	localparam logic [7:0] RST_CLKDIV = 8'h00;
	localparam logic [7:0] MASK_POWER_MODE = 8'h0C;
	localparam logic [7:0] MASK_STRETCH = 8'h07;
	localparam logic [7:0] MASK_CLKDIV = 8'h1F;
	localparam int DIV_W = 15;
	localparam int RAM_DEPTH = 256;
	localparam int DEBOUNCE_NS = 1000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_W = 14;
	typedef enum logic [2:0] {
		CPRC_RUN = 3'b001,
		CPRC_IDLE = 3'b010,
		CPRC_STOP = 3'b100
	} cprc_pm_t;
endpackage : cprc_pkg

// ---- hdl/cprc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cprc_top
	import cprc_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
	input wire logic mclk_in, // System clock
	input wire logic rst_in, // Power-on/brown-out reset, high
	input wire logic external_reset_low_in, // Reset pin, low, async
	input wire logic sfr_wr_in, // SFR write strobe
	input wire logic sfr_rd_in, // SFR read strobe
	input wire logic [7:0] sfr_addr_in, // SFR address
	input wire logic [7:0] sfr_wdata_in, // SFR write data
	output logic [7:0] sfr_rdata_out, // SFR read data
	output logic sfr_hit_out, // Address belongs to this block
	input wire logic irq_active_in, // Processor is servicing an interrupt
	input wire logic irq_pending_in, // Any enabled interrupt pending
	input wire logic external_interrupt_zero_in, // Pin, async level
	input wire logic external_interrupt_one_in, // Pin, async level
	input wire logic debug_wake_in, // Debug port wake level
	input wire logic spi_rx_wake_in, // SPI receive or overrun level
	input wire logic twi_wake_in, // Two-wire interface wake level
	output logic cpu_clk_en_out, // Processor clock enable
	output logic periph_clk_en_out, // Internal clock enable
	output logic sys_reset_out, // Device-wide reset, high
	output logic [2:0] stretch_out, // Stretch value
	output logic [3:0] rd_addr_width_out, // Read address cycles
	output logic [3:0] rd_strobe_width_out, // Read strobe cycles
	output logic [3:0] wr_addr_width_out, // Write address cycles
	output logic [3:0] wr_strobe_width_out, // Write strobe cycles
	input wire logic [7:0] iram_addr_in, // Internal RAM address
	input wire logic iram_we_in, // Internal RAM write
	input wire logic [7:0] iram_wdata_in, // Internal RAM data in
	output logic [7:0] iram_rdata_out, // Internal RAM data out
	output logic iram_busy_out // RAM clear in progress
);
	logic [7:0] power_mode_control_r;
	logic [7:0] memory_stretch_control_r;
	logic [7:0] clock_divide_control_r;
	cprc_pm_t pm_r;
	logic soft_rst_r;
	logic [2:0] pin_rst_sync_r;
	logic [2:0] external_interrupt_zero_sync_r;
	logic [2:0] external_interrupt_one_sync_r;
	logic pin_rst_lvl_r;
	logic [DEB_W-1:0] deb_cnt_r;
	logic [DIV_W-1:0] div_cnt_r;
	logic cpu_tick_r;
	logic [7:0] clr_addr_r;
	logic clr_busy_r;
	logic [7:0] iram_mem [RAM_DEPTH];
	logic any_rst;
	logic wr_pm, wr_st, wr_cd;
	logic stop_wake;
	logic [3:0] divsel;
	logic [DIV_W-1:0] div_mask;
	logic full_speed;

	// Three-stage sync; only stages 2 and 3 feed logic
	always_ff @(posedge mclk_in) begin
		pin_rst_sync_r <= {pin_rst_sync_r[1:0], ~external_reset_low_in};
		external_interrupt_zero_sync_r <= {external_interrupt_zero_sync_r[1:0], external_interrupt_zero_in};
		external_interrupt_one_sync_r <= {external_interrupt_one_sync_r[1:0], external_interrupt_one_in};
	end

	// Bounce on a switch must settle before the level is accepted
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pin_rst_lvl_r <= 1'b0;
			deb_cnt_r <= '0;
		end else if ((pin_rst_sync_r[2] == pin_rst_sync_r[1])
				&& (pin_rst_sync_r[2] != pin_rst_lvl_r)) begin
			if (deb_cnt_r >= DEB_W'(DEBOUNCE_CYCLES - 1)) begin
				pin_rst_lvl_r <= pin_rst_sync_r[2];
				deb_cnt_r <= '0;
			end else begin
				deb_cnt_r <= deb_cnt_r + 1'b1;
			end
		end else begin
			deb_cnt_r <= '0;
		end
	end

	assign any_rst = rst_in || pin_rst_lvl_r || soft_rst_r;
	assign sys_reset_out = any_rst;

	assign wr_pm = sfr_wr_in && (sfr_addr_in == ADDR_POWER_MODE);
	assign wr_st = sfr_wr_in && (sfr_addr_in == ADDR_STRETCH);
	assign wr_cd = sfr_wr_in && (sfr_addr_in == ADDR_CLKDIV);

	always_ff @(posedge mclk_in) begin
		if (any_rst) begin
			power_mode_control_r <= RST_POWER_MODE;
			memory_stretch_control_r <= RST_STRETCH;
			clock_divide_control_r <= RST_CLKDIV;
		end else begin
			if (wr_pm && pm_r == CPRC_RUN) begin
				power_mode_control_r <= sfr_wdata_in & MASK_POWER_MODE;
			end
			if (wr_st && pm_r == CPRC_RUN) begin
				memory_stretch_control_r <= sfr_wdata_in & MASK_STRETCH;
			end
			if (wr_cd && pm_r == CPRC_RUN) begin
				clock_divide_control_r <= sfr_wdata_in & MASK_CLKDIV;
			end
		end
	end

	// Soft reset pulse lasts one cycle, then clears itself via reset
	always_ff @(posedge mclk_in) begin
		if (rst_in || soft_rst_r) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_cd && sfr_wdata_in[BIT_SOFTWARE_RESET_TRIGGER];
		end
	end

	// Stop wake uses levels only; no internal interrupt is looked at
	// A pin level counts only once stages 2 and 3 agree
	assign stop_wake = (external_interrupt_zero_sync_r[2] && external_interrupt_zero_sync_r[1])
		|| (external_interrupt_one_sync_r[2] && external_interrupt_one_sync_r[1])
		|| debug_wake_in || spi_rx_wake_in || twi_wake_in;

	always_ff @(posedge mclk_in) begin
		if (any_rst) begin
			pm_r <= CPRC_RUN;
		end else begin
			case (pm_r)
				CPRC_RUN: begin
					if (wr_pm && sfr_wdata_in[BIT_STOP]) begin
						pm_r <= CPRC_STOP;
					end else if (wr_pm && sfr_wdata_in[BIT_IDLE]) begin
						pm_r <= CPRC_IDLE;
					end
				end
				CPRC_IDLE: begin
					if (irq_pending_in) begin
						pm_r <= CPRC_RUN;
					end
				end
				CPRC_STOP: begin
					if (stop_wake) begin
						pm_r <= CPRC_RUN;
					end
				end
				default: pm_r <= CPRC_RUN;
			endcase
		end
	end

	assign divsel = clock_divide_control_r[3:0];
	assign div_mask = DIV_W'((32'h1 << divsel) - 32'h1);
	assign full_speed = irq_active_in && !clock_divide_control_r[BIT_IRQSPD];

	// Divider counts only with internal clocking running
	always_ff @(posedge mclk_in) begin
		if (any_rst) begin
			div_cnt_r <= '0;
			cpu_tick_r <= 1'b0;
		end else if (pm_r == CPRC_STOP) begin
			div_cnt_r <= '0;
			cpu_tick_r <= 1'b0;
		end else begin
			div_cnt_r <= ((div_cnt_r & div_mask) == div_mask) ? '0 : div_cnt_r + 1'b1;
			cpu_tick_r <= full_speed || ((div_cnt_r & div_mask) == div_mask);
		end
	end

	assign cpu_clk_en_out = cpu_tick_r && (pm_r == CPRC_RUN);
	assign periph_clk_en_out = (pm_r != CPRC_STOP);

	assign stretch_out = memory_stretch_control_r[2:0];
	always_comb begin
		rd_addr_width_out = {1'b0, stretch_out} + 4'h1;
		rd_strobe_width_out = {1'b0, stretch_out} + 4'h1;
		wr_addr_width_out = {1'b0, stretch_out} + 4'h2;
		wr_strobe_width_out = (stretch_out < 3'h2) ? 4'h1 : {1'b0, stretch_out};
	end

	always_comb begin
		sfr_hit_out = 1'b0;
		sfr_rdata_out = 8'h00;
		if (sfr_addr_in == ADDR_POWER_MODE) begin
			sfr_hit_out = 1'b1;
			sfr_rdata_out = power_mode_control_r & MASK_POWER_MODE;
		end else if (sfr_addr_in == ADDR_STRETCH) begin
			sfr_hit_out = 1'b1;
			sfr_rdata_out = memory_stretch_control_r;
		end else if (sfr_addr_in == ADDR_CLKDIV) begin
			sfr_hit_out = 1'b1;
			sfr_rdata_out = clock_divide_control_r & MASK_CLKDIV;
		end
		if (!sfr_rd_in) begin
			sfr_rdata_out = 8'h00;
		end
	end

	// Clears one byte per cycle; the external 1K block lives elsewhere
	always_ff @(posedge mclk_in) begin
		if (any_rst) begin
			clr_busy_r <= 1'b1;
			clr_addr_r <= 8'h00;
		end else if (clr_busy_r) begin
			clr_addr_r <= clr_addr_r + 8'h01;
			if (clr_addr_r == 8'hFF) begin
				clr_busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (clr_busy_r) begin
			iram_mem[clr_addr_r] <= 8'h00;
		end else if (iram_we_in) begin
			iram_mem[iram_addr_in] <= iram_wdata_in;
		end
		iram_rdata_out <= clr_busy_r ? 8'h00 : iram_mem[iram_addr_in];
	end
	assign iram_busy_out = clr_busy_r;

	always_ff @(posedge mclk_in) begin
		if (!rst_in && pm_r == CPRC_IDLE) begin
			idle_clk_a: assert (!cpu_clk_en_out && periph_clk_en_out)
				else $error("idle clocking wrong");
		end
	end

	stop_clk_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(pm_r == CPRC_STOP) |-> (!cpu_clk_en_out && !periph_clk_en_out))
		else $error("stop clocking wrong");
	read_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(sfr_rd_in && sfr_addr_in == ADDR_POWER_MODE) |-> (sfr_rdata_out[1:0] == 2'b00))
		else $error("mode bits read nonzero");
	soft_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(sfr_rd_in && sfr_addr_in == ADDR_CLKDIV) |-> !sfr_rdata_out[7])
		else $error("soft reset read one");
	soft_reset_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr_cd && sfr_wdata_in[BIT_SOFTWARE_RESET_TRIGGER] && !soft_rst_r) |=> sys_reset_out)
		else $error("soft reset missing");
	idle_wake_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(pm_r == CPRC_IDLE && irq_pending_in && !any_rst) |=> (pm_r == CPRC_RUN))
		else $error("idle not left");
	stop_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(pm_r == CPRC_STOP && !stop_wake && !any_rst) |=> (pm_r == CPRC_STOP))
		else $error("stop left without wake");
	wr_width_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr_addr_width_out == rd_addr_width_out + 4'h1))
		else $error("write address width wrong");
	full_speed_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(full_speed && pm_r == CPRC_RUN && !any_rst)[*2] |-> cpu_clk_en_out)
		else $error("interrupt not full speed");
	ram_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		$fell(any_rst) |-> clr_busy_r[*8])
		else $error("ram clear too short");
endmodule : cprc_top
`default_nettype wire
